// ### hw/ufc_regs.svh
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH
// ****************************************************************
// Register byte addresses on the Wishbone bus.
// ****************************************************************
`define UFC_ADDR_DATA 4'h0
`define UFC_ADDR_INT_EN 4'h1
`define UFC_ADDR_FIFO_CTL 4'h2
`define UFC_ADDR_INT_STAT 4'h2
`define UFC_ADDR_LINE_STAT 4'h5
`define UFC_ADDR_RXLVL 4'h8
`define UFC_ADDR_TXLVL 4'h9
`define UFC_ADDR_FLWH 4'hA
`define UFC_ADDR_FLWL 4'hB
`define UFC_ADDR_STAT 4'hC
`define UFC_ADDR_MASK 4'hD
// ****************************************************************
// FIFO control field positions.
// ****************************************************************
`define UFC_FC_EN 0
`define UFC_FC_RXCLR 1
`define UFC_FC_TXCLR 2
`define UFC_FC_TXT_LO 4
`define UFC_FC_RXT_LO 6
// ****************************************************************
// Reset values and sizes.
// ****************************************************************
`define UFC_RST_FC 8'h00
`define UFC_RST_BYTE 8'h00
`define UFC_FIFO_DEPTH 32
`define UFC_PTR_W 5
`define UFC_CNT_W 6
`endif

// ### hw/ufc_pkg.sv
package ufc_pkg;
  typedef logic [1:0] ufc_trig_t;
  typedef logic [5:0] ufc_cnt_t;
  typedef enum logic [1:0] {
    UFC_IDLE = 2'b00,
    UFC_ACK = 2'b01
  } ufc_bus_t;
endpackage

// ### hw/ufc_core.sv
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ufc_regs.svh"
// Operation
// - Zero enables give polled mode; irq still follows stat and mask.
// - Status bit 0 set while receive FIFO nonempty.
// - Status bits 4:1 report error kinds.
// - Status bit 5 means transmit FIFO empty.
// - Bit 6 needs FIFO and shifter empty.
// - Bit 7 flags errors held in FIFO.
// - Control bit 0 enables both FIFOs.
// - Control bit 1 clears receive FIFO, self-clears.
// - Control bit 2 clears transmit FIFO, self-clears.
// - Bits 7:6 pick receive trigger level.
// - Receive ready when count reaches trigger.
// - Bits 5:4 pick transmit trigger level.
// - Transmit empty when count below trigger.
// - Nonzero level registers override trigger fields.
// - Data ready set on push, cleared empty.
// - Transmit interrupt cleared by interrupt status read or data write.
module ufc_core
  import ufc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_push,
  input wire logic [7:0] rx_data,
  input wire logic [2:0] rx_err,
  input wire logic rx_break,
  input wire logic tx_pop,
  output logic [7:0] tx_data,
  output logic tx_avail,
  input wire logic shift_empty,
  output logic rx_ready_irq,
  output logic tx_empty_irq,
  output logic irq
);
  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Receive trigger decode; the top entry is 28, not 32, so no arithmetic.
  function automatic ufc_cnt_t rx_trig(input ufc_trig_t s);
    unique case (s)
      2'b00: rx_trig = 6'd8;
      2'b01: rx_trig = 6'd16;
      2'b10: rx_trig = 6'd24;
      2'b11: rx_trig = 6'd28;
    endcase
  endfunction
  function automatic ufc_cnt_t tx_trig(input ufc_trig_t s);
    unique case (s)
      2'b00: tx_trig = 6'd16;
      2'b01: tx_trig = 6'd8;
      2'b10: tx_trig = 6'd24;
      2'b11: tx_trig = 6'd30;
    endcase
  endfunction
  // Level registers saturate at the FIFO depth so a large setting stays reachable.
  function automatic ufc_cnt_t lvl_cap(input logic [7:0] v);
    lvl_cap = (v > 8'd32) ? 6'd32 : v[5:0];
  endfunction

  // ****************************************************************
  // State.
  // ****************************************************************
  ufc_bus_t bus_q, bus_d;
  logic [7:0] fc_q, fc_d, ien_q, ien_d, rxl_q, rxl_d, txl_q, txl_d;
  logic [7:0] fh_q, fh_d, fl_q, fl_d, stat_q, stat_d, mask_q, mask_d, rdat_q, rdat_d;
  logic [10:0] rxm [0:`UFC_FIFO_DEPTH-1];
  logic [7:0] txm [0:`UFC_FIFO_DEPTH-1];
  logic [`UFC_PTR_W-1:0] rwp_q, rwp_d, rrp_q, rrp_d, twp_q, twp_d, trp_q, trp_d;
  ufc_cnt_t rcnt_q, rcnt_d, tcnt_q, tcnt_d;
  logic [5:0] errn_q, errn_d;
  logic [3:0] lerr_q, lerr_d;
  logic txi_q, txi_d, rxr_q, txe_q;
  logic req, wr, rd, ctl_wr, rx_clr, tx_clr, fen, ovr, rx_wr, rx_rd, tx_wr, tx_rd;
  logic rx_full, tx_full, rx_hit, tx_low, data_rd, int_stat_rd, tx_load;
  ufc_cnt_t rx_lvl, tx_lvl;
  logic [7:0] line_stat, int_stat, rd_mux;
  logic [10:0] rx_head;

  // Bus strobes; writes take effect at the acking edge.
  assign req = wb_cyc_i && wb_stb_i && (bus_q == UFC_IDLE);
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i && (bus_q == UFC_ACK);
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && (bus_q == UFC_ACK);
  assign ctl_wr = wr && (wb_adr_i == `UFC_ADDR_FIFO_CTL);
  assign rx_clr = ctl_wr && wb_dat_i[`UFC_FC_RXCLR];
  assign tx_clr = ctl_wr && wb_dat_i[`UFC_FC_TXCLR];
  assign data_rd = rd && (wb_adr_i == `UFC_ADDR_DATA);
  // Reading the interrupt status, like loading a character, retires a pending transmit interrupt.
  assign int_stat_rd = rd && (wb_adr_i == `UFC_ADDR_INT_STAT);
  assign tx_load = wr && (wb_adr_i == `UFC_ADDR_DATA);
  assign fen = fc_q[`UFC_FC_EN];
  // Without FIFOs each direction acts as a one-byte holding register.
  assign rx_full = fen ? (rcnt_q == 6'd32) : (rcnt_q != 6'd0);
  assign tx_full = fen ? (tcnt_q == 6'd32) : (tcnt_q != 6'd0);
  assign rx_wr = rx_push && !rx_full && !rx_clr;
  assign ovr = rx_push && rx_full;
  assign rx_rd = data_rd && (rcnt_q != 6'd0) && !rx_clr;
  assign tx_wr = tx_load && !tx_full && !tx_clr;
  assign tx_rd = tx_pop && (tcnt_q != 6'd0) && !tx_clr;
  assign rx_head = rxm[rrp_q];

  // Trigger selection; any nonzero level register switches the source.
  always_comb begin
    if ((rxl_q | txl_q | fh_q | fl_q) != 8'h00) begin
      rx_lvl = lvl_cap(rxl_q);
      tx_lvl = lvl_cap(txl_q);
    end else begin
      rx_lvl = rx_trig(fc_q[`UFC_FC_RXT_LO +: 2]);
      tx_lvl = tx_trig(fc_q[`UFC_FC_TXT_LO +: 2]);
    end
  end
  assign rx_hit = fen ? (rcnt_q >= rx_lvl) : (rcnt_q != 6'd0);
  assign tx_low = fen ? (tcnt_q < tx_lvl) : (tcnt_q == 6'd0);

  // Line status: overrun, parity, framing, break sit in 4:1.
  assign line_stat = {(errn_q != 6'd0), (tcnt_q == 6'd0) && shift_empty, (tcnt_q == 6'd0),
                      lerr_q, (rcnt_q != 6'd0)};
  // Interrupt status reports receive ahead of transmit; bits 7:6 mirror the enable.
  assign int_stat = {fen, fen, 2'b00, rxr_q ? 4'b0100 : (txe_q ? 4'b0010 : 4'b0001)};

  // The receive and transmit interrupt lines are gated by the enables; irq follows stat and mask only.
  // The receive level is compared every cycle, so draining below it drops the line at once.
  assign rxr_q = rx_hit && ien_q[0];
  assign txe_q = txi_q && ien_q[1];
  assign rx_ready_irq = rxr_q;
  assign tx_empty_irq = txe_q;
  assign irq = (stat_q & mask_q) != 8'h00;

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    bus_d = req ? UFC_ACK : UFC_IDLE;
    fc_d = fc_q;
    ien_d = ien_q;
    rxl_d = rxl_q;
    txl_d = txl_q;
    fh_d = fh_q;
    fl_d = fl_q;
    mask_d = mask_q;
    stat_d = stat_q;
    lerr_d = lerr_q;
    txi_d = txi_q;
    rd_mux = 8'h00;
    unique case (wb_adr_i)
      `UFC_ADDR_DATA: rd_mux = rx_head[7:0];
      `UFC_ADDR_INT_EN: rd_mux = ien_q;
      `UFC_ADDR_INT_STAT: rd_mux = int_stat;
      `UFC_ADDR_LINE_STAT: rd_mux = line_stat;
      `UFC_ADDR_RXLVL: rd_mux = rxl_q;
      `UFC_ADDR_TXLVL: rd_mux = txl_q;
      `UFC_ADDR_FLWH: rd_mux = fh_q;
      `UFC_ADDR_FLWL: rd_mux = fl_q;
      `UFC_ADDR_STAT: rd_mux = stat_q;
      `UFC_ADDR_MASK: rd_mux = mask_q;
      default: rd_mux = 8'h00;
    endcase
    rdat_d = req ? rd_mux : rdat_q;
    if (wr) begin
      unique case (wb_adr_i)
        // Clear bits are never stored and bit 3 is dropped.
        `UFC_ADDR_FIFO_CTL: fc_d = wb_dat_i & 8'hF1;
        `UFC_ADDR_INT_EN: ien_d = wb_dat_i;
        `UFC_ADDR_RXLVL: rxl_d = wb_dat_i;
        `UFC_ADDR_TXLVL: txl_d = wb_dat_i;
        `UFC_ADDR_FLWH: fh_d = wb_dat_i;
        `UFC_ADDR_FLWL: fl_d = wb_dat_i;
        `UFC_ADDR_MASK: mask_d = wb_dat_i;
        `UFC_ADDR_STAT: stat_d = stat_q & ~wb_dat_i;
        default: ;
      endcase
    end
    // Error bits clear on a status read; new errors win over the clear.
    if (rd && (wb_adr_i == `UFC_ADDR_LINE_STAT)) lerr_d = 4'h0;
    if (rx_wr) lerr_d = lerr_d | {rx_break, rx_err};
    if (ovr) lerr_d[0] = 1'b1;
    if (rx_rd && (rx_head[10:8] != 3'b000)) lerr_d = lerr_d | {1'b0, rx_head[10:8]};
    // Transmit-empty latch: set on drain below level, cleared by read or load.
    if (int_stat_rd || tx_load) txi_d = 1'b0;
    // A pop that crosses the level sets it again; the later assignment lets the set win.
    if (tx_rd && (tcnt_q == tx_lvl) || tx_clr || (txi_q == 1'b0 && tx_low && !tx_load
        && !int_stat_rd && tx_rd)) txi_d = 1'b1;
    // Sticky events: rx level, tx empty, line error, overrun; set beats clear.
    stat_d = stat_d | {4'h0, ovr, (rx_wr && (rx_err != 3'b000 || rx_break)),
                       tx_rd && (tcnt_q == 6'd1), rx_wr && (rcnt_q + 6'd1 == rx_lvl)};
  end

  // FIFO pointers and counts.
  always_comb begin
    rwp_d = rwp_q + (rx_wr ? 5'd1 : 5'd0);
    rrp_d = rrp_q + (rx_rd ? 5'd1 : 5'd0);
    rcnt_d = rcnt_q + (rx_wr ? 6'd1 : 6'd0) - (rx_rd ? 6'd1 : 6'd0);
    errn_d = errn_q + ((rx_wr && rx_err != 3'b000) ? 6'd1 : 6'd0)
             - ((rx_rd && rx_head[10:8] != 3'b000) ? 6'd1 : 6'd0);
    twp_d = twp_q + (tx_wr ? 5'd1 : 5'd0);
    trp_d = trp_q + (tx_rd ? 5'd1 : 5'd0);
    tcnt_d = tcnt_q + (tx_wr ? 6'd1 : 6'd0) - (tx_rd ? 6'd1 : 6'd0);
    // Clearing also happens when the FIFO enable changes, as both contents go stale.
    if (rx_clr || (ctl_wr && wb_dat_i[`UFC_FC_EN] != fen)) begin
      rwp_d = 5'd0;
      rrp_d = 5'd0;
      rcnt_d = 6'd0;
      errn_d = 6'd0;
    end
    if (tx_clr || (ctl_wr && wb_dat_i[`UFC_FC_EN] != fen)) begin
      twp_d = 5'd0;
      trp_d = 5'd0;
      tcnt_d = 6'd0;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus_q <= UFC_IDLE;
      fc_q <= `UFC_RST_FC;
      ien_q <= `UFC_RST_BYTE;
      rxl_q <= `UFC_RST_BYTE;
      txl_q <= `UFC_RST_BYTE;
      fh_q <= `UFC_RST_BYTE;
      fl_q <= `UFC_RST_BYTE;
      stat_q <= `UFC_RST_BYTE;
      mask_q <= `UFC_RST_BYTE;
      rdat_q <= `UFC_RST_BYTE;
      rwp_q <= 5'd0;
      rrp_q <= 5'd0;
      twp_q <= 5'd0;
      trp_q <= 5'd0;
      rcnt_q <= 6'd0;
      tcnt_q <= 6'd0;
      errn_q <= 6'd0;
      lerr_q <= 4'h0;
      txi_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      fc_q <= fc_d;
      ien_q <= ien_d;
      rxl_q <= rxl_d;
      txl_q <= txl_d;
      fh_q <= fh_d;
      fl_q <= fl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdat_q <= rdat_d;
      rwp_q <= rwp_d;
      rrp_q <= rrp_d;
      twp_q <= twp_d;
      trp_q <= trp_d;
      rcnt_q <= rcnt_d;
      tcnt_q <= tcnt_d;
      errn_q <= errn_d;
      lerr_q <= lerr_d;
      txi_q <= txi_d;
    end
  end

  // Storage arrays carry no reset; the data register and tx_data read them even when the FIFO is empty.
  always_ff @(posedge mclk) begin
    if (rx_wr) rxm[rwp_q] <= {rx_err, rx_data};
    if (tx_wr) txm[twp_q] <= wb_dat_i;
  end

  assign wb_ack_o = (bus_q == UFC_ACK);
  assign wb_dat_o = rdat_q;
  assign tx_data = txm[trp_q];
  assign tx_avail = (tcnt_q != 6'd0);

  // ****************************************************************
  // Checks.
  // ****************************************************************
  // With every enable clear neither rx_ready_irq nor tx_empty_irq may rise, whatever the FIFOs hold.
  a_polled_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    (ien_q[3:0] == 4'h0) |-> !rx_ready_irq && !tx_empty_irq)
    else $error("interrupt raised in polled mode");
  // Data ready tracks the receive count exactly.
  a_ready_bit: assert property (@(posedge mclk) disable iff (!rstn)
    line_stat[0] == (rcnt_q != 6'd0))
    else $error("data ready disagrees with count");
  // A character entering the FIFO shows as data ready on the next cycle.
  a_push_ready: assert property (@(posedge mclk) disable iff (!rstn)
    rx_wr |=> line_stat[0])
    else $error("push did not set data ready");
  // Bit 6 may only be high while both the FIFO and the shifter are idle.
  a_tx_empty: assert property (@(posedge mclk) disable iff (!rstn)
    line_stat[6] |-> line_stat[5] && shift_empty)
    else $error("transmitter empty without both empty");
  // A receive clear empties the FIFO and leaves no clear bit behind.
  a_rx_clear: assert property (@(posedge mclk) disable iff (!rstn)
    rx_clr |=> (rcnt_q == 6'd0) && !fc_q[`UFC_FC_RXCLR])
    else $error("receive clear failed");
  // A transmit clear empties the FIFO and leaves no clear bit behind.
  a_tx_clear: assert property (@(posedge mclk) disable iff (!rstn)
    tx_clr |=> (tcnt_q == 6'd0) && !fc_q[`UFC_FC_TXCLR])
    else $error("transmit clear failed");
  // The reserved control bit is never kept.
  a_rsvd_bit: assert property (@(posedge mclk) disable iff (!rstn)
    !fc_q[3])
    else $error("reserved bit stored");
  // The highest receive field setting fires at exactly its level.
  a_rx_trig: assert property (@(posedge mclk) disable iff (!rstn)
    fen && ien_q[0] && (rxl_q | txl_q | fh_q | fl_q) == 8'h00 && fc_q[7:6] == 2'b11
    && rcnt_q == 6'd28 |-> rx_ready_irq)
    else $error("receive trigger 28 missed");
  // The transmit field decode is not monotonic, so one setting is pinned.
  a_tx_trig: assert property (@(posedge mclk) disable iff (!rstn)
    (rxl_q | txl_q | fh_q | fl_q) == 8'h00 && fc_q[5:4] == 2'b01 |-> tx_lvl == 6'd8)
    else $error("transmit trigger decode wrong");
  // An interrupt status read retires the transmit interrupt.
  a_tx_irqclr: assert property (@(posedge mclk) disable iff (!rstn)
    int_stat_rd && !tx_rd |=> !txi_q)
    else $error("status read kept transmit interrupt");
  // Transmit empty bit follows the transmit count.
  a_tx_empty_bit: assert property (@(posedge mclk) disable iff (!rstn)
    line_stat[5] == (tcnt_q == 6'd0))
    else $error("transmit empty bit disagrees with count");
  // A stored error character raises the held-error flag.
  a_err_push: assert property (@(posedge mclk) disable iff (!rstn)
    rx_wr && (rx_err != 3'b000) && !ctl_wr |=> line_stat[7])
    else $error("held error flag missed");
  // A received break is reported in bit 4.
  a_brk_report: assert property (@(posedge mclk) disable iff (!rstn)
    rx_wr && rx_break |=> line_stat[4])
    else $error("break not reported");
  // The enable bit takes the written value.
  a_fifo_en: assert property (@(posedge mclk) disable iff (!rstn)
    ctl_wr |=> fen == $past(wb_dat_i[`UFC_FC_EN]))
    else $error("fifo enable not stored");
  // At or above the receive level the enabled line is up.
  a_rx_level: assert property (@(posedge mclk) disable iff (!rstn)
    fen && ien_q[0] && (rcnt_q >= rx_lvl) |-> rx_ready_irq)
    else $error("receive level reached without interrupt");
  // One short of the lowest field level stays quiet.
  a_rx_trig8: assert property (@(posedge mclk) disable iff (!rstn)
    fen && ien_q[0] && (rxl_q | txl_q | fh_q | fl_q) == 8'h00 && fc_q[7:6] == 2'b00
    && rcnt_q == 6'd7 |-> !rx_ready_irq)
    else $error("receive trigger 8 fired early");
  // A pop from exactly the level, leaving the count one below it, latches the transmit interrupt.
  a_tx_below: assert property (@(posedge mclk) disable iff (!rstn)
    tx_rd && (tcnt_q == tx_lvl) |=> txi_q)
    else $error("transmit level crossing missed");
  // A nonzero level register replaces the field decode.
  a_lvl_override: assert property (@(posedge mclk) disable iff (!rstn)
    rxl_q == 8'h03 |-> rx_lvl == 6'd3)
    else $error("level register ignored");
  // Loading a character retires the transmit interrupt.
  a_load_clr: assert property (@(posedge mclk) disable iff (!rstn)
    tx_load && !tx_rd |=> !txi_q)
    else $error("load kept transmit interrupt");
  // Acknowledge is a single-cycle pulse.
  a_ack_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  // A character written to a full transmit FIFO is dropped.
  a_full_drop: assert property (@(posedge mclk) disable iff (!rstn)
    tx_load && tx_full && !tx_rd |=> tcnt_q == $past(tcnt_q))
    else $error("write to full transmit fifo counted");
  // Main scenarios: full receive FIFO, both interrupts, full drain, held error.
  c_fill_rx: cover property (@(posedge mclk) disable iff (!rstn) rx_full && fen);
  c_rx_irq: cover property (@(posedge mclk) disable iff (!rstn) $rose(rx_ready_irq));
  c_tx_irq: cover property (@(posedge mclk) disable iff (!rstn) $rose(tx_empty_irq));
  c_tx_drain: cover property (@(posedge mclk) disable iff (!rstn) $rose(line_stat[6]));
  c_err: cover property (@(posedge mclk) disable iff (!rstn) $rose(line_stat[7]));
endmodule

// ### tb/ufc_shifter_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Serial side stand-in: receive shifter and transmit shifter.
// ****************************************************************
module ufc_shifter_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic send_req,
  input wire logic [7:0] send_data,
  input wire logic [3:0] send_flags,
  input wire logic drain_req,
  input wire logic tx_avail,
  input wire logic [7:0] tx_data,
  output logic rx_push,
  output logic [7:0] rx_data,
  output logic [2:0] rx_err,
  output logic rx_break,
  output logic tx_pop,
  output logic shift_empty,
  output logic [7:0] got_byte
);
  logic [3:0] shift_q;
  // One push per request; between pushes the data lines toggle so stale data never passes.
  // A pop is taken only while data is offered, then the shifter stays busy for 12 cycles.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_push <= 1'b0;
      rx_data <= 8'h00;
      rx_err <= 3'h0;
      rx_break <= 1'b0;
      tx_pop <= 1'b0;
      got_byte <= 8'h00;
      shift_q <= 4'h0;
    end else begin
      rx_push <= send_req;
      rx_data <= send_req ? send_data : ~rx_data;
      rx_err <= send_req ? send_flags[2:0] : 3'h0;
      rx_break <= send_req & send_flags[3];
      tx_pop <= drain_req & tx_avail;
      if (tx_pop) begin
        got_byte <= tx_data;
        shift_q <= 4'hC;
      end else if (shift_q != 4'h0) begin
        shift_q <= shift_q - 4'h1;
      end
    end
  end
  // The shifter reports empty only when no character is in flight.
  assign shift_empty = (shift_q == 4'h0) && !tx_pop;
endmodule

// ### tb/test_uart_fifo_control_polling.sv
`timescale 1ns/1ps
`include "ufc_regs.svh"
module test_uart_fifo_control_polling;
  logic mclk, rstn, cyc, stb, we, sel, sreq, dreq;
  logic [3:0] adr, sflg;
  logic [7:0] dat, sdat, dat_o, txd, rxd, got, q;
  logic ack, push, pop, tav, tse, brk, rirq, tirq, irq;
  logic [2:0] rerr;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  int fail_count = 0;
  int checks = 0;
  int t;
  // ****************************************************************
  // Clock, design and serial side.
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ufc_core dut_u (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rx_push(push), .rx_data(rxd), .rx_err(rerr), .rx_break(brk), .tx_pop(pop),
    .tx_data(txd), .tx_avail(tav), .shift_empty(tse), .rx_ready_irq(rirq),
    .tx_empty_irq(tirq), .irq(irq));
  ufc_shifter_model sh_u (.mclk(mclk), .rstn(rstn), .send_req(sreq), .send_data(sdat),
    .send_flags(sflg), .drain_req(dreq), .tx_avail(tav), .tx_data(txd), .rx_push(push),
    .rx_data(rxd), .rx_err(rerr), .rx_break(brk), .tx_pop(pop), .shift_empty(tse),
    .got_byte(got));
  // ****************************************************************
  // Expectations, bus cycles and helpers.
  // ****************************************************************
  function automatic int rx_lvl(input int k);
    return (k == 3) ? 28 : 8 * (k + 1);
  endfunction
  function automatic int tx_lvl(input int k);
    return (k == 0) ? 16 : (k == 1) ? 8 : (k == 2) ? 24 : 30;
  endfunction
  task automatic conclude();
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Ack is sampled at the rising edge; the write lands and read data is taken there.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      conclude();
    end
    q = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic status_is(input logic [7:0] e);
    xfer(1'b0, `UFC_ADDR_LINE_STAT, 8'h00);
    check("line_status", q, e);
  endtask
  task automatic idle();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic send(input logic [7:0] d, input logic [3:0] f);
    @(posedge mclk);
    {sreq, sdat, sflg} <= {1'b1, d, f};
    rxq.push_back(d);
    @(posedge mclk);
    sreq <= 1'b0;
    idle();
  endtask
  task automatic pop_one();
    @(posedge mclk);
    dreq <= 1'b1;
    @(posedge mclk);
    dreq <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    check("tx_byte", got, txq.pop_front());
  endtask
  initial begin
    #400us;
    fail_count++;
    conclude();
  end
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    {rstn, cyc, stb, we, sel, sreq, dreq, adr, sflg, dat, sdat} = '0;
    void'($urandom(32'hdfb90146));
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    sel <= 1'b1;
    status_is(8'h60);
    wr(4'h7, 8'hFF);
    xfer(1'b0, 4'h7, 8'h00);
    check("unmapped", q, 8'h00);
    wr(`UFC_ADDR_INT_EN, 8'h00);
    wr(`UFC_ADDR_FIFO_CTL, 8'h01);
    // Polled mode: data arrives but no interrupt may rise.
    for (int i = 0; i < 8; i++) send(8'($urandom), 4'h0);
    check("rx_irq", {7'h0, rirq}, 8'h00);
    check("tx_irq", {7'h0, tirq}, 8'h00);
    status_is(8'h61);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, `UFC_ADDR_DATA, 8'h00);
      check("rx_byte", q, rxq.pop_front());
    end
    status_is(8'h60);
    // Each error kind shows alone and clears on read; an errored character other than a break
    // reports its kind again when it is read out. A break is not a data error in bit 7.
    for (int i = 0; i < 4; i++) begin
      send(8'($urandom), 4'(1 << i));
      status_is(8'h61 | ((i < 3) ? 8'h80 : 8'h00) | 8'(2 << i));
      status_is(8'h61 | ((i < 3) ? 8'h80 : 8'h00));
      xfer(1'b0, `UFC_ADDR_DATA, 8'h00);
      check("err_byte", q, rxq.pop_front());
      status_is(8'h60 | ((i < 3) ? 8'(2 << i) : 8'h00));
    end
    // Receive trigger: one short of the level stays quiet, the level fires.
    wr(`UFC_ADDR_INT_EN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(`UFC_ADDR_FIFO_CTL, 8'(k << 6) | 8'h03 | 8'(($urandom & 1) << 3));
      for (int i = 1; i < rx_lvl(k); i++) send(8'($urandom), 4'h0);
      check("rx_irq", {7'h0, rirq}, 8'h00);
      send(8'($urandom), 4'h0);
      check("rx_irq", {7'h0, rirq}, 8'h01);
      wr(`UFC_ADDR_FIFO_CTL, 8'(k << 6) | 8'h03);
      rxq.delete();
      idle();
      check("rx_irq", {7'h0, rirq}, 8'h00);
      status_is(8'h60);
    end
    // Transmit trigger: the clear sets the interrupt and the loads retire it; it then rises only when the count drops below the level.
    wr(`UFC_ADDR_INT_EN, 8'h02);
    for (int k = 0; k < 4; k++) begin
      wr(`UFC_ADDR_FIFO_CTL, 8'(k << 4) | 8'h05);
      status_is(8'h60);
      for (int i = 0; i <= tx_lvl(k); i++) begin
        txq.push_back(8'($urandom));
        wr(`UFC_ADDR_DATA, txq[$]);
      end
      idle();
      check("tx_irq", {7'h0, tirq}, 8'h00);
      pop_one();
      idle();
      check("tx_irq", {7'h0, tirq}, 8'h00);
      pop_one();
      idle();
      check("tx_irq", {7'h0, tirq}, 8'h01);
      xfer(1'b0, `UFC_ADDR_INT_STAT, 8'h00);
      idle();
      check("tx_irq", {7'h0, tirq}, 8'h00);
      wr(`UFC_ADDR_FIFO_CTL, 8'(k << 4) | 8'h05);
      txq.delete();
      status_is(8'h60);
    end
    // Last character leaves the FIFO while the shifter is still busy.
    txq.push_back(8'h5A);
    wr(`UFC_ADDR_DATA, 8'h5A);
    status_is(8'h00);
    pop_one();
    status_is(8'h20);
    repeat (14) @(posedge mclk);
    status_is(8'h60);
    // A nonzero level register overrides the field; the sticky event then drives irq.
    wr(`UFC_ADDR_FIFO_CTL, 8'h03);
    wr(`UFC_ADDR_RXLVL, 8'h03);
    wr(`UFC_ADDR_INT_EN, 8'h01);
    wr(`UFC_ADDR_MASK, 8'h00);
    wr(`UFC_ADDR_STAT, 8'h0F);
    for (t = 0; t < 2; t++) send(8'($urandom), 4'h0);
    check("rx_irq", {7'h0, rirq}, 8'h00);
    send(8'($urandom), 4'h0);
    check("rx_irq", {7'h0, rirq}, 8'h01);
    check("irq", {7'h0, irq}, 8'h00);
    wr(`UFC_ADDR_MASK, 8'h01);
    idle();
    check("irq", {7'h0, irq}, 8'h01);
    wr(`UFC_ADDR_STAT, 8'h01);
    idle();
    check("irq", {7'h0, irq}, 8'h00);
    conclude();
  end
endmodule
